// ### core/ext_bus_expansion.sv
// External bus expansion controller: mode registers, pin muxing, bus cycles
`timescale 1ns/100ps

module ext_bus_expansion
    import ext_bus_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [15:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic cpu_req_valid,
    input wire cpu_req_s cpu_req,
    output logic cpu_done,
    output logic cpu_ext,
    output logic [7:0] cpu_rdata,
    input wire logic [7:0] port4_out,
    input wire logic [7:0] port4_oe,
    input wire logic [3:0] port6_out,
    input wire logic [3:0] port6_oe,
    input wire logic [7:0] port6_direction_reg,
    input wire logic [7:0] port4_pins_i,
    output logic [7:0] port4_pins_o,
    output logic [7:0] port4_pins_oe,
    input wire logic [3:0] port6_upper_pins_i,
    output logic [3:0] port6_upper_pins_o,
    output logic [3:0] port6_upper_pins_oe
);

    logic [2:0] xmode_r;
    logic [7:0] wcfg_r;
    logic [7:0] size_r;
    logic [7:0] sfr_rdata_r;

    bus_state_e state_r;
    cpu_req_s req_r;
    logic ext_r;
    logic wcnt_r;
    logic done_r;
    logic [7:0] rdata_r;
    logic [7:0] ad_o_r;
    logic [7:0] ad_oe_r;
    logic [2:0] ctrl_o_r;
    logic [2:0] ctrl_oe_r;
    logic wait_o_r;
    logic wait_oe_r;

    logic [1:0] wait_mode;
    logic ext_wait_sel;
    logic wait_held;
    logic fin;
    logic accept;

    assign wait_mode = {wcfg_r[WAIT_HI_POS], wcfg_r[WAIT_LO_POS]};
    // External waiting only counts once the pin has been turned to input
    assign ext_wait_sel = (wait_mode == WAIT_EXT) && port6_direction_reg[WAIT_DIR_BIT];
    assign wait_held = ext_wait_sel && !port6_upper_pins_i[P6_WAIT];
    assign accept = (state_r == S_IDLE) && cpu_req_valid && !done_r;

    // Strobe phase ends at once for internal targets; prohibited wait code acts as none
    always_comb begin
        fin = 1'b1;
        if (ext_r) begin
            if (wait_mode == WAIT_ONE) begin
                fin = wcnt_r;
            end else if (wait_mode == WAIT_EXT) begin
                fin = !wait_held;
            end
        end
    end

    // Control registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            xmode_r <= EXPMODE_RST[2:0];
            wcfg_r <= WAITCFG_RST;
            size_r <= SIZESEL_RST;
        end else if (sfr_wr) begin
            if (sfr_addr == EXPMODE_ADDR) begin
                // Upper bits have no storage and are dropped; the whole register is write-only and reads zero
                xmode_r <= sfr_wdata[2:0] & EXPMODE_USED;
            end else if (sfr_addr == WAITCFG_ADDR) begin
                wcfg_r <= sfr_wdata & WAITCFG_USED;
            end else if (sfr_addr == SIZESEL_ADDR) begin
                size_r <= sfr_wdata;
            end
        end
    end

    // Register read port; the mode register is write-only and reads zero
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sfr_rdata_r <= 8'h00;
        end else if (sfr_rd) begin
            if (sfr_addr == WAITCFG_ADDR) begin
                sfr_rdata_r <= wcfg_r;
            end else if (sfr_addr == SIZESEL_ADDR) begin
                sfr_rdata_r <= size_r;
            end else begin
                sfr_rdata_r <= 8'h00;
            end
        end
    end

    // Bus cycle engine; also owns port 4 and the three strobe pins
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r <= S_IDLE;
            req_r <= '0;
            ext_r <= 1'b0;
            wcnt_r <= 1'b0;
            done_r <= 1'b0;
            rdata_r <= 8'h00;
            ad_o_r <= 8'h00;
            ad_oe_r <= 8'h00;
            ctrl_o_r <= 3'h0;
            ctrl_oe_r <= 3'h0;
        end else begin
            done_r <= 1'b0;
            case (state_r)
                S_IDLE: begin
                    if (!exp_on(xmode_r)) begin
                        // Single-chip: pins are plain ports
                        ad_o_r <= port4_out;
                        ad_oe_r <= port4_oe;
                        ctrl_o_r <= {port6_out[3], port6_out[1], port6_out[0]};
                        ctrl_oe_r <= {port6_oe[3], port6_oe[1], port6_oe[0]};
                        if (accept) begin
                            req_r <= cpu_req;
                            ext_r <= 1'b0;
                            done_r <= 1'b1;
                        end
                    end else begin
                        ctrl_oe_r <= 3'h7;
                        ctrl_o_r <= CTRL_IDLE;
                        ad_oe_r <= 8'h00;
                        if (accept) begin
                            req_r <= cpu_req;
                            ext_r <= win_hit(size_r, cpu_req.addr);
                            // Latch strobe and address go out for every cycle
                            ctrl_o_r[C_ALS] <= 1'b1;
                            ad_o_r <= cpu_req.addr[7:0];
                            ad_oe_r <= 8'hff;
                            state_r <= S_ADDR;
                        end
                    end
                end
                S_ADDR: begin
                    ctrl_o_r[C_ALS] <= 1'b0;
                    wcnt_r <= 1'b0;
                    state_r <= S_STRB;
                    if (ext_r && req_r.write) begin
                        ctrl_o_r[C_WR] <= 1'b0;
                        ad_o_r <= req_r.wdata;
                    end else if (ext_r) begin
                        ctrl_o_r[C_RD] <= 1'b0;
                        ad_oe_r <= 8'h00;
                    end
                end
                S_STRB: begin
                    if (fin) begin
                        ctrl_o_r[C_RD] <= 1'b1;
                        ctrl_o_r[C_WR] <= 1'b1;
                        ad_oe_r <= 8'h00;
                        done_r <= 1'b1;
                        state_r <= S_IDLE;
                        if (ext_r && !req_r.write) begin
                            rdata_r <= port4_pins_i;
                        end
                    end else begin
                        wcnt_r <= 1'b1;
                    end
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end

    // Wait pin is a port bit unless expansion mode with external wait control is selected
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wait_o_r <= 1'b0;
            wait_oe_r <= 1'b0;
        end else if (exp_on(xmode_r) && wait_mode == WAIT_EXT) begin
            wait_o_r <= 1'b0;
            wait_oe_r <= 1'b0;
        end else begin
            wait_o_r <= port6_out[P6_WAIT];
            wait_oe_r <= port6_oe[P6_WAIT];
        end
    end

    assign sfr_rdata = sfr_rdata_r;
    assign cpu_done = done_r;
    assign cpu_ext = ext_r;
    assign cpu_rdata = rdata_r;
    assign port4_pins_o = ad_o_r;
    assign port4_pins_oe = ad_oe_r;
    assign port6_upper_pins_o = {ctrl_o_r[C_ALS], wait_o_r, ctrl_o_r[C_WR], ctrl_o_r[C_RD]};
    assign port6_upper_pins_oe = {ctrl_oe_r[C_ALS], wait_oe_r, ctrl_oe_r[C_WR],
                                  ctrl_oe_r[C_RD]};

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    a_rd_internal_high: assert property (
        (state_r != S_IDLE && !ext_r && exp_on(xmode_r)) |-> ctrl_o_r[C_RD] && ctrl_o_r[C_WR])
        else $error("strobe active on internal cycle");

    a_rd_only_read: assert property (
        (state_r != S_IDLE && !ctrl_o_r[C_RD]) |-> ext_r && !req_r.write)
        else $error("read strobe without external read");

    a_wr_only_write: assert property (
        (state_r != S_IDLE && !ctrl_o_r[C_WR]) |-> ext_r && req_r.write)
        else $error("write strobe without external write");

    a_als_every_cycle: assert property (
        (accept && exp_on(xmode_r)) |=> ctrl_o_r[C_ALS] ##1 !ctrl_o_r[C_ALS])
        else $error("latch strobe not pulsed for one cycle");

    a_addr_on_strobe: assert property (
        (state_r == S_ADDR) |-> ad_oe_r == 8'hff && ad_o_r == req_r.addr[7:0])
        else $error("address not on bus during latch strobe");

    a_one_wait_state: assert property (
        (state_r == S_ADDR && ext_r && wait_mode == WAIT_ONE) |=> !done_r ##1 !done_r ##1 done_r)
        else $error("one wait state not two strobe cycles");

    a_no_wait_state: assert property (
        (state_r == S_ADDR && ext_r && wait_mode == WAIT_NONE) |=> !done_r ##1 done_r)
        else $error("no wait cycle not one strobe cycle");

    a_ext_wait_hold: assert property (
        (state_r == S_STRB && ext_r && wait_held) |=> !done_r && state_r == S_STRB)
        else $error("cycle ended while wait asserted");

    a_internal_no_wait: assert property (
        (state_r == S_STRB && !ext_r) |=> done_r && state_r == S_IDLE)
        else $error("internal cycle stretched");

    a_wait_pin_port: assert property (
        (wait_mode != WAIT_EXT) |=> wait_oe_r == $past(port6_oe[P6_WAIT]))
        else $error("wait pin not following port latch");

    a_mode_clear: assert property (
        $fell(rst) |-> xmode_r == EXPMODE_RST[2:0] && wcfg_r == WAITCFG_RST
            && size_r == SIZESEL_RST)
        else $error("register reset values wrong");

    a_mode_reads_zero: assert property (
        (sfr_rd && sfr_addr == EXPMODE_ADDR) |=> sfr_rdata_r == 8'h00)
        else $error("write-only mode register read nonzero");

    a_single_chip_one: assert property (
        (accept && !exp_on(xmode_r)) |=> done_r && state_r == S_IDLE)
        else $error("single-chip cycle not one clock");

    a_expand_pins: assert property (
        (state_r != S_IDLE) |-> ctrl_oe_r == 3'h7)
        else $error("strobe pins not driven during bus cycle");

    a_wait_pin_input: assert property (
        (exp_on(xmode_r) && wait_mode == WAIT_EXT) |=> !wait_oe_r)
        else $error("wait pin driven while used as wait input");

    a_strobe_ends_done: assert property (
        (state_r == S_STRB && fin) |=> done_r && state_r == S_IDLE)
        else $error("finished strobe phase did not complete");

    a_strobes_high_done: assert property (
        (done_r && ext_r) |-> ctrl_o_r[C_RD] && ctrl_o_r[C_WR])
        else $error("strobe still low after cycle end");

    a_write_data_out: assert property (
        (state_r == S_STRB && ext_r && req_r.write) |-> ad_oe_r == 8'hff
            && ad_o_r == req_r.wdata)
        else $error("write data not driven during write strobe");

    a_read_bus_free: assert property (
        (state_r == S_STRB && ext_r && !req_r.write) |-> ad_oe_r == 8'h00)
        else $error("bus driven during read strobe");

    a_bus_off_done: assert property (
        (done_r && ext_r) |-> ad_oe_r == 8'h00)
        else $error("bus still driven after external cycle");

    a_wait_pin_out: assert property (
        (wait_mode != WAIT_EXT) |=> wait_o_r == $past(port6_out[P6_WAIT]))
        else $error("wait pin level not following port latch");

    a_no_window_top: assert property (
        (accept && exp_on(xmode_r) && size_r == SIZESEL_RST) |=> !ext_r)
        else $error("window used with largest internal size");

endmodule // ext_bus_expansion

// ### core/ext_bus_pkg.sv
// Constants, types and helpers for the external bus expansion controller
package ext_bus_pkg;

    localparam logic [15:0] EXPMODE_ADDR = 16'hff47;
    localparam logic [15:0] WAITCFG_ADDR = 16'hfff8;
    localparam logic [15:0] SIZESEL_ADDR = 16'hfff0;

    localparam logic [7:0] EXPMODE_RST = 8'h00;
    localparam logic [7:0] WAITCFG_RST = 8'h10;
    localparam logic [7:0] SIZESEL_RST = 8'hcf;

    localparam logic [2:0] EXPMODE_USED = 3'h7;
    localparam logic [1:0] EXPMODE_EXP_CODE = 2'h1;
    localparam int WAIT_LO_POS = 4;
    localparam int WAIT_HI_POS = 5;
    localparam logic [7:0] WAITCFG_USED = 8'h30;

    localparam logic [1:0] WAIT_NONE = 2'h0;
    localparam logic [1:0] WAIT_ONE = 2'h1;
    localparam logic [1:0] WAIT_EXT = 2'h3;

    localparam logic [7:0] SIZE_16K = 8'hc4;
    localparam logic [7:0] SIZE_24K = 8'hc6;
    localparam logic [7:0] SIZE_32K = 8'hc8;
    localparam logic [7:0] SIZE_48K = 8'hcc;
    localparam logic [7:0] TOP_16K = 8'h40;
    localparam logic [7:0] TOP_24K = 8'h60;
    localparam logic [7:0] TOP_32K = 8'h80;
    localparam logic [7:0] TOP_48K = 8'hc0;

    // Index of each control strobe within the module's strobe vector
    localparam int C_RD = 0;
    localparam int C_WR = 1;
    localparam int C_ALS = 2;
    // Port 6 upper nibble: 0 read, 1 write, 2 wait, 3 latch strobe
    localparam int P6_WAIT = 2;
    localparam int WAIT_DIR_BIT = 6;
    localparam logic [2:0] CTRL_IDLE = 3'h3;

    typedef struct packed {
        logic fetch;
        logic write;
        logic [15:0] addr;
        logic [7:0] wdata;
    } cpu_req_s;

    typedef enum logic [1:0] {S_IDLE, S_ADDR, S_STRB} bus_state_e;

    function automatic logic exp_on(input logic [2:0] sel);
        exp_on = (sel[2:1] == EXPMODE_EXP_CODE);
    endfunction

    // Window only for the smaller ROM codes; the largest setting has none
    function automatic logic win_hit(input logic [7:0] size, input logic [15:0] addr);
        logic [7:0] top;
        logic ok;
        top = 8'h00;
        ok = 1'b1;
        case (size)
            SIZE_16K: top = TOP_16K;
            SIZE_24K: top = TOP_24K;
            SIZE_32K: top = TOP_32K;
            SIZE_48K: top = TOP_48K;
            default: ok = 1'b0;
        endcase
        win_hit = ok && (addr[15:8] == top);
    endfunction

endpackage

// ### bench/ext_mem_model.sv
// Behavioural external memory with address latch and wait generator
`timescale 1ns/100ps

module ext_mem_model (
    input wire logic ref_clk,
    input wire logic [7:0] ad_out,
    input wire logic [3:0] ctl,
    input wire logic [3:0] wait_len,
    input wire logic hold_wait,
    output logic [7:0] ad_in,
    output logic wait_n
);
    logic [7:0] mem [0:255];
    logic [7:0] lat_addr;
    logic [7:0] idle_q;
    logic [3:0] wcnt;
    logic strb_q;
    logic fresh;

    initial begin
        lat_addr = 8'h00;
        idle_q = 8'h00;
        wcnt = 4'h0;
        strb_q = 1'b1;
    end

    assign fresh = strb_q && !(ctl[0] && ctl[1]);
    // Released bus never holds its last value, so a missed sample shows up
    assign ad_in = ctl[0] ? idle_q : mem[lat_addr];
    assign wait_n = !(fresh || wcnt != 4'h0 || hold_wait);

    // Clocked latch: samples the bus at each clock edge while the strobe is high, keeps it after the fall
    always @(posedge ref_clk) begin
        if (ctl[3]) begin
            lat_addr <= ad_out;
        end
        if (!ctl[1]) begin
            mem[lat_addr] <= ad_out;
        end
        strb_q <= ctl[0] && ctl[1];
        idle_q <= ~ad_in;
        if (fresh && wait_len != 4'h0) begin
            wcnt <= wait_len - 4'h1;
        end else if (wcnt != 4'h0) begin
            wcnt <= wcnt - 4'h1;
        end
    end
endmodule // ext_mem_model

// ### bench/tb.sv
// Self-checking testbench for the external bus expansion controller
`timescale 1ns/100ps

module tb;
    import ext_bus_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] sfr_addr = 16'h0000;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata, cpu_rdata, p4o, p4oe, ad_in;
    logic cpu_req_valid = 1'b0;
    cpu_req_s cpu_req = '0;
    logic cpu_done, cpu_ext, wait_n;
    logic [7:0] port4_out = 8'h00;
    logic [7:0] port4_oe = 8'h00;
    logic [3:0] port6_out = 4'h0;
    logic [3:0] port6_oe = 4'h0;
    logic [3:0] p6o, p6oe, wait_len = 4'h0;
    logic hold_wait = 1'b0;
    logic [31:0] seed = 32'h547c8958;
    int miscompares = 0;
    int total_checks = 0;
    int n;
    logic [2:0] seen;
    logic [7:0] top, d, w;
    logic [15:0] a;
    logic [7:0] codes [4] = '{SIZE_16K, SIZE_24K, SIZE_32K, SIZE_48K};
    logic [7:0] tops [4] = '{TOP_16K, TOP_24K, TOP_32K, TOP_48K};

    always #10 ref_clk = ~ref_clk;

    ext_bus_expansion dut (.ref_clk(ref_clk), .rst(rst), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .cpu_req_valid(cpu_req_valid), .cpu_req(cpu_req), .cpu_done(cpu_done),
        .cpu_ext(cpu_ext), .cpu_rdata(cpu_rdata), .port4_out(port4_out),
        .port4_oe(port4_oe), .port6_out(port6_out), .port6_oe(port6_oe),
        .port6_direction_reg(8'h40), .port4_pins_i((p4oe & p4o) | (~p4oe & ad_in)),
        .port4_pins_o(p4o), .port4_pins_oe(p4oe),
        .port6_upper_pins_i({p6o[3], p6oe[2] ? p6o[2] : wait_n, p6o[1:0]}),
        .port6_upper_pins_o(p6o), .port6_upper_pins_oe(p6oe));

    ext_mem_model mem (.ref_clk(ref_clk), .ad_out(p4o), .ctl(p6o), .wait_len(wait_len),
        .hold_wait(hold_wait), .ad_in(ad_in), .wait_n(wait_n));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    function automatic int exp_cyc(input logic [7:0] wc, input logic [3:0] len);
        return (wc == 8'h10) ? 4 : (wc == 8'h30) ? 3 + int'(len) : 3;
    endfunction

    task automatic results();
        if (miscompares == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] sv, input logic [15:0] ev);
        total_checks++;
        if (sv !== ev) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, ev, sv);
        end
    endtask

    task automatic reg_wr(input logic [15:0] ad, input logic [7:0] dv);
        @(negedge ref_clk);
        sfr_addr = ad;
        sfr_wdata = dv;
        sfr_wr = 1'b1;
        @(negedge ref_clk);
        sfr_wr = 1'b0;
    endtask

    task automatic reg_chk(input logic [15:0] ad, input logic [7:0] ev);
        @(negedge ref_clk);
        sfr_addr = ad;
        sfr_rd = 1'b1;
        @(negedge ref_clk);
        sfr_rd = 1'b0;
        chk("sfr_rdata", {8'h00, sfr_rdata}, {8'h00, ev});
    endtask

    task automatic cpu(input logic wr, input logic [15:0] ad, input logic [7:0] dv);
        @(negedge ref_clk);
        seed = lfsr(seed);
        cpu_req = '{fetch: !wr && seed[0], write: wr, addr: ad, wdata: dv};
        cpu_req_valid = 1'b1;
        n = 0;
        seen = 3'b000;
        do begin
            @(negedge ref_clk);
            n++;
            seen |= {p6o[3], ~p6o[1], ~p6o[0]};
        end while (cpu_done !== 1'b1 && n < 40);
        if (n >= 40) begin
            miscompares++;
            results();
        end
        cpu_req_valid = 1'b0;
        @(negedge ref_clk);
    endtask

    initial begin
        repeat (16) @(negedge ref_clk);
        rst = 1'b0;
        reg_chk(WAITCFG_ADDR, WAITCFG_RST);
        reg_chk(SIZESEL_ADDR, SIZESEL_RST);
        reg_chk(EXPMODE_ADDR, 8'h00);
        reg_chk(16'hff00, 8'h00);
        seed = lfsr(seed);
        {port4_out, port4_oe, port6_out, port6_oe} = seed[23:0];
        repeat (2) @(negedge ref_clk);
        chk("port4_pins_o", {8'h00, p4o}, {8'h00, port4_out});
        chk("port6_pins_oe", {12'h000, p6oe}, {12'h000, port6_oe});
        cpu(1'b0, 16'h4012, 8'h00);
        chk("single_chip_cycles", 16'(n), 16'd1);
        reg_wr(WAITCFG_ADDR, 8'hff);
        reg_chk(WAITCFG_ADDR, WAITCFG_USED);
        for (int k = 0; k < 16; k++) begin
            w = {2'b00, 2'(k), 4'h0};
            top = tops[k / 4];
            seed = lfsr(seed);
            a = {top, seed[7:0]};
            d = seed[15:8];
            wait_len = 4'(seed[17:16]) + 4'h1;
            port6_out = seed[23:20];
            reg_wr(SIZESEL_ADDR, codes[k / 4]);
            reg_wr(EXPMODE_ADDR, k[0] ? 8'h03 : 8'h02);
            reg_wr(WAITCFG_ADDR, w);
            cpu(1'b1, a, d);
            chk("wr_cycles", 16'(n), 16'(exp_cyc(w, wait_len)));
            chk("wr_strobes", {13'h0, seen}, 16'h0006);
            chk("wr_ext", {15'h0, cpu_ext}, 16'h0001);
            cpu(1'b0, a, 8'h00);
            chk("rd_cycles", 16'(n), 16'(exp_cyc(w, wait_len)));
            chk("rd_strobes", {13'h0, seen}, 16'h0005);
            chk("rd_data", {8'h00, cpu_rdata}, {8'h00, d});
            hold_wait = 1'b1;
            cpu(1'b0, {top - 8'h01, seed[31:24]}, 8'h00);
            hold_wait = 1'b0;
            chk("int_cycles", 16'(n), 16'd3);
            chk("int_strobes", {13'h0, seen}, 16'h0004);
            chk("int_ext", {15'h0, cpu_ext}, 16'h0000);
            if (w != 8'h30) begin
                chk("wait_pin_port", {15'h0, p6o[P6_WAIT]},
                    {15'h0, port6_out[P6_WAIT]});
            end
        end
        reg_wr(EXPMODE_ADDR, 8'h04);
        cpu(1'b0, 16'h4012, 8'h00);
        chk("prohibited_cycles", 16'(n), 16'd1);
        // Upper bits dropped, so code 010 selects expansion; wait mode is still external
        reg_wr(EXPMODE_ADDR, 8'hfa);
        cpu(1'b0, 16'hc012, 8'h00);
        chk("upper_bits_cycles", 16'(n), 16'(exp_cyc(w, wait_len)));
        results();
    end
endmodule // tb
